// ==== bench/kei_key_model.sv ====
// Purpose: key switch model for the port 7 key inputs
// Assumes: pull-ups are enabled on every key pin
// Notes: a released key floats to the pull-up level, never to a stale value
`timescale 1ns/1ps
module kei_key_model (
  // pressed keys from the bench
  input wire logic [7:0] press,
  // pin levels seen by the device
  output logic [7:0] key_input_pin
);
  // pressed key shorts to ground, released pin sits high on its pull-up
  assign key_input_pin = ~press;
endmodule : kei_key_model

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the key edge interrupt block
// Assumes: pins settle four edges after a change, irq is a one-cycle pulse
// Notes: a four-key copy shares the inputs to check the narrow build
`timescale 1ns/1ps
`include "kei_regs.svh"
module testbench;
  import kei_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [19:0] reg_addr = 20'h00000;
  kei_acc_t reg_acc = KEI_ACC_NONE;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] reg_bit = 3'h0;
  logic [7:0] press = 8'h00;
  logic [7:0] latch = 8'h5a;
  logic [7:0] rdata, rdata4, pin_out, pin_oe, pin_level, pins;
  logic hit, key_irq;
  int num_errors = 0;
  int check_count = 0;
  int irq_cnt = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  kei_key_model model_u (.press(press), .key_input_pin(pins));
  kei_key_irq #(.NUM_KEYS(8)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_acc(reg_acc),
    .reg_wdata(reg_wdata), .reg_bit(reg_bit), .reg_rdata(rdata), .reg_hit(hit), .key_input_pin(pins),
    .port7_out_latch(latch), .port7_pin_out(pin_out), .port7_pin_oe(pin_oe), .port7_pin_level(pin_level),
    .key_irq(key_irq));
  kei_key_irq #(.NUM_KEYS(4)) dut4_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_acc(reg_acc),
    .reg_wdata(reg_wdata), .reg_bit(reg_bit), .reg_rdata(rdata4), .reg_hit(), .key_input_pin(pins),
    .port7_out_latch(latch), .port7_pin_out(), .port7_pin_oe(), .port7_pin_level(), .key_irq());
  // pulse counter and hang guard; the run needs well under 400 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (key_irq === 1'b1) irq_cnt++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task wt(input int n);
    repeat (n) step();
  endtask : wt
  // one access cycle, released 1 ns after the edge that takes it
  task wr(input logic [19:0] a, input kei_acc_t k, input logic [7:0] d, input logic [2:0] b);
    step();
    reg_addr = a;
    reg_acc = k;
    reg_wdata = d;
    reg_bit = b;
    step();
    reg_acc = KEI_ACC_NONE;
  endtask : wr
  // combinational read, looked at mid-cycle
  task rd(input logic [19:0] a, input logic [7:0] exp);
    step();
    reg_addr = a;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask : rd
  initial begin
    wt(12);
    sys_rst = 1'b0;
    rd(`KEI_KEY_EN_ADDR, `KEI_KEY_EN_RESET);
    rd(`KEI_DIR_ADDR, `KEI_DIR_RESET);
    chk({7'h00, hit}, 8'h01);
    chk(pin_oe, 8'h00);
    rd(20'h0ff38, 8'h00);
    chk({7'h00, hit}, 8'h00);
    $display("test reset done");
    // disabled pin falls, then an enabled one; holding low gives no repeat
    step();
    press = 8'h80;
    wt(10);
    chk(irq_cnt[7:0], 8'h00);
    wr(`KEI_KEY_EN_ADDR, KEI_ACC_BIT_SET, 8'h00, 3'h0);
    rd(`KEI_KEY_EN_ADDR, 8'h01);
    step();
    press = 8'h81;
    wt(10);
    chk(irq_cnt[7:0], 8'h01);
    step();
    press = 8'h00;
    wt(10);
    chk(irq_cnt[7:0], 8'h01);
    $display("test edge done");
    // enabling a pin already low raises one request
    step();
    press = 8'h08;
    wt(10);
    chk(irq_cnt[7:0], 8'h01);
    wr(`KEI_KEY_EN_ADDR, KEI_ACC_BIT_SET, 8'h00, 3'h3);
    wt(5);
    chk(irq_cnt[7:0], 8'h02);
    // software holds the low level past the minimum width before clearing the flag
    wt((`KEI_LOW_WIDTH_NS + `KEI_CLK_PERIOD_NS - 1) / `KEI_CLK_PERIOD_NS);
    chk(irq_cnt[7:0], 8'h02);
    // two enabled pins falling together give one pulse
    step();
    press = 8'h00;
    wt(10);
    step();
    press = 8'h09;
    wt(10);
    chk(irq_cnt[7:0], 8'h03);
    chk(pin_level, 8'hf6);
    $display("test low enable done");
    // single bit clear, byte writes, narrow build, unmapped write
    wr(`KEI_KEY_EN_ADDR, KEI_ACC_BIT_CLR, 8'h00, 3'h0);
    rd(`KEI_KEY_EN_ADDR, 8'h08);
    wr(`KEI_KEY_EN_ADDR, KEI_ACC_BYTE, 8'hff, 3'h0);
    rd(`KEI_KEY_EN_ADDR, 8'hff);
    chk(rdata4, 8'h0f);
    wr(20'h0ff38, KEI_ACC_BYTE, 8'h00, 3'h0);
    rd(`KEI_KEY_EN_ADDR, 8'hff);
    wr(`KEI_DIR_ADDR, KEI_ACC_BYTE, 8'h05, 3'h0);
    rd(`KEI_DIR_ADDR, 8'h05);
    chk(rdata4, 8'hf5);
    chk(pin_oe, 8'hfa);
    chk(pin_out, 8'h5a);
    wr(`KEI_DIR_ADDR, KEI_ACC_BIT_SET, 8'h00, 3'h1);
    rd(`KEI_DIR_ADDR, 8'h07);
    wr(`KEI_DIR_ADDR, KEI_ACC_BIT_CLR, 8'h00, 3'h2);
    rd(`KEI_DIR_ADDR, 8'h03);
    chk(rdata4, 8'hf3);
    chk(pin_oe, 8'hfc);
    step();
    latch = 8'ha5;
    @(negedge ref_clk);
    chk(pin_out, 8'ha5);
    $display("test registers done");
    // a second reset in mid-run restores both registers
    step();
    sys_rst = 1'b1;
    wt(2);
    sys_rst = 1'b0;
    rd(`KEI_KEY_EN_ADDR, `KEI_KEY_EN_RESET);
    rd(`KEI_DIR_ADDR, `KEI_DIR_RESET);
    $display("test mid reset done");
    close_out();
  end
endmodule : testbench

// ==== verilog/kei_key_irq.sv ====
// Purpose: key input falling-edge detector with port 7 direction register
// Assumes: cpu writes bytes or single bits through the access port
// Notes: irq pulse goes to the cpu's interrupt controller flag
//
// What this block does
// - falling edge on an enabled key pin raises the shared key interrupt.
// - enable bit 0 ignores its pin; 1 makes it eligible.
// - every key pin has its own enable bit.
// - four or eight key inputs; in four-input build upper enables read zero.
// - enable register resets to 00h, writable by byte or single bit.
// - setting an enable while its pin is low also raises the interrupt.
// - pins with enable clear stay plain port pins.
// - direction bit 0 drives the pin, 1 makes it an input.
// - direction register resets to ffh, writable by byte or bit.
// - interrupt priority level never affects the request.
`timescale 1ns/1ps
`include "kei_regs.svh"
module kei_key_irq #(
  parameter int NUM_KEYS = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // cpu register access
  input wire logic [`KEI_ADDR_W-1:0] reg_addr,
  input wire kei_pkg::kei_acc_t reg_acc,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] reg_bit,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // port 7 pins
  input wire logic [7:0] key_input_pin,
  input wire logic [7:0] port7_out_latch,
  output logic [7:0] port7_pin_out,
  output logic [7:0] port7_pin_oe,
  output logic [7:0] port7_pin_level,
  // interrupt request to the controller
  output logic key_irq
);
  import kei_pkg::*;

  // bits above the build width are tied off rather than left free
  localparam logic [7:0] USED_MASK = (NUM_KEYS == 4) ? 8'h0f : 8'hff;

  // only the four- and eight-key builds exist; refuse others at elaboration
  if (NUM_KEYS != 4 && NUM_KEYS != 8) begin : g_bad_keys
    $error("kei_key_irq: NUM_KEYS must be 4 or 8");
  end

  logic [7:0] key_detect_enable_reg_r;
  logic [7:0] key_detect_enable_reg_nxt;
  logic [7:0] port7_direction_reg_r;
  logic [7:0] port7_direction_reg_nxt;
  logic [7:0] key_lvl;
  logic [7:0] key_prev_r;
  logic [7:0] key_prev_nxt;
  logic [7:0] fall_hit;
  logic [7:0] arm_hit;
  logic irq_r;
  logic irq_nxt;
  logic hit_en;
  logic hit_dir;
  logic [7:0] bit_mask;

  // one synchroniser per pin; idle level is high because of the pull-up
  // all eight are kept in the narrow build so pin_level still shows every pin
  // the cost is four idle synchronisers, traded for one port map for both builds
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_sync
      kei_sync #(.RESET_VAL(1'b1)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(key_input_pin[g]),
        .level_out(key_lvl[g])
      );
    end
  endgenerate

  // address decode
  always_comb begin
    hit_en = 1'b0;
    hit_dir = 1'b0;
    if (reg_addr == `KEI_KEY_EN_ADDR) begin
      hit_en = 1'b1;
    end else if (reg_addr == `KEI_DIR_ADDR) begin
      hit_dir = 1'b1;
    end
  end

  assign bit_mask = 8'h01 << reg_bit;

  // register writes; byte or single-bit manipulation
  always_comb begin
    key_detect_enable_reg_nxt = key_detect_enable_reg_r;
    port7_direction_reg_nxt = port7_direction_reg_r;
    if (hit_en) begin
      case (reg_acc)
        KEI_ACC_BYTE: key_detect_enable_reg_nxt = reg_wdata;
        KEI_ACC_BIT_SET: key_detect_enable_reg_nxt = key_detect_enable_reg_r | bit_mask;
        KEI_ACC_BIT_CLR: key_detect_enable_reg_nxt = key_detect_enable_reg_r & ~bit_mask;
        default: key_detect_enable_reg_nxt = key_detect_enable_reg_r;
      endcase
    end
    if (hit_dir) begin
      case (reg_acc)
        KEI_ACC_BYTE: port7_direction_reg_nxt = reg_wdata;
        KEI_ACC_BIT_SET: port7_direction_reg_nxt = port7_direction_reg_r | bit_mask;
        KEI_ACC_BIT_CLR: port7_direction_reg_nxt = port7_direction_reg_r & ~bit_mask;
        default: port7_direction_reg_nxt = port7_direction_reg_r;
      endcase
    end
    // unused upper enables stay zero in the narrow build
    key_detect_enable_reg_nxt = key_detect_enable_reg_nxt & USED_MASK;
    // unused direction bits stay input in the narrow build
    port7_direction_reg_nxt = port7_direction_reg_nxt | ~USED_MASK;
  end

  // edge detection; priority settings never enter here
  // the arm term looks at the next enable so the pulse leaves on the write edge
  always_comb begin
    key_prev_nxt = key_lvl;
    // falling edge on an enabled pin
    fall_hit = key_prev_r & ~key_lvl & key_detect_enable_reg_r;
    // newly enabled while already low acts as an edge
    arm_hit = ~key_detect_enable_reg_r & key_detect_enable_reg_nxt & ~key_lvl;
    irq_nxt = |(fall_hit | arm_hit);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_detect_enable_reg_r <= `KEI_KEY_EN_RESET;
      port7_direction_reg_r <= `KEI_DIR_RESET;
      key_prev_r <= 8'hff;
      irq_r <= 1'b0;
    end else begin
      key_detect_enable_reg_r <= key_detect_enable_reg_nxt;
      port7_direction_reg_r <= port7_direction_reg_nxt;
      key_prev_r <= key_prev_nxt;
      irq_r <= irq_nxt;
    end
  end

  // read mux; unmapped addresses read zero and drop reg_hit
  always_comb begin
    reg_rdata = 8'h00;
    reg_hit = 1'b0;
    if (hit_en) begin
      reg_rdata = key_detect_enable_reg_r;
      reg_hit = 1'b1;
    end else if (hit_dir) begin
      reg_rdata = port7_direction_reg_r;
      reg_hit = 1'b1;
    end
  end

  // pin drivers: the detector never touches them, so plain port use survives
  assign port7_pin_out = port7_out_latch;
  assign port7_pin_oe = ~port7_direction_reg_r;
  assign port7_pin_level = key_lvl;
  assign key_irq = irq_r;

  // the low-width wait before clearing the flag is software's job; no timer here
  // this keeps a counter out of the block that would only serve one start-up case

  // assertions: request path first
  fall_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|($past(key_lvl) & ~key_lvl & key_detect_enable_reg_r)) |=> key_irq)
    else $error("enabled falling edge did not raise irq");
  masked_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (key_detect_enable_reg_r == 8'h00 && key_detect_enable_reg_nxt == 8'h00) |=> !key_irq)
    else $error("irq with all enables clear");
  // a fall on a disabled pin, with no enable write, must stay silent
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!(|($past(key_lvl) & ~key_lvl & key_detect_enable_reg_r)) && !(hit_en && reg_acc != KEI_ACC_NONE))
      |=> !key_irq)
    else $error("irq without an enabled fall or an enable write");
  arm_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|(~key_detect_enable_reg_r & key_detect_enable_reg_nxt & ~key_lvl)) |=> key_irq)
    else $error("enable on low pin gave no irq");
  irq_cause_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    key_irq |-> $past(irq_nxt))
    else $error("irq without a cause");

  // enable register writes
  bit_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_en && reg_acc == KEI_ACC_BIT_SET) |=>
      ((key_detect_enable_reg_r ^ $past(key_detect_enable_reg_r)) & ~$past(bit_mask)) == 8'h00)
    else $error("bit write touched another enable");
  bit_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_en && reg_acc == KEI_ACC_BIT_CLR) |=>
      (key_detect_enable_reg_r == ($past(key_detect_enable_reg_r) & ~$past(bit_mask))))
    else $error("bit clear changed the wrong enable");
  narrow_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (key_detect_enable_reg_r & ~USED_MASK) == 8'h00)
    else $error("unused enable bits not zero");
  byte_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_en && reg_acc == KEI_ACC_BYTE) |=> key_detect_enable_reg_r == ($past(reg_wdata) & USED_MASK))
    else $error("enable byte write lost");

  // direction register and pin drivers
  narrow_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (port7_direction_reg_r | USED_MASK) == 8'hff)
    else $error("unused direction bits left output");
  dir_oe_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_dir && reg_acc == KEI_ACC_BIT_CLR && (bit_mask & USED_MASK) != 8'h00) |=>
      (port7_pin_oe & $past(bit_mask)) != 8'h00)
    else $error("direction bit clear did not enable driver");
  dir_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_dir && reg_acc == KEI_ACC_BYTE) |=> port7_direction_reg_r == ($past(reg_wdata) | ~USED_MASK))
    else $error("direction byte write lost");
  dir_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_dir && reg_acc == KEI_ACC_BIT_SET) |=>
      (port7_direction_reg_r == ($past(port7_direction_reg_r) | $past(bit_mask))))
    else $error("direction bit set changed the wrong bit");
  dir_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hit_dir && reg_acc == KEI_ACC_BIT_CLR) |=>
      (port7_direction_reg_r == (($past(port7_direction_reg_r) & ~$past(bit_mask)) | ~USED_MASK)))
    else $error("direction bit clear changed the wrong bit");
endmodule : kei_key_irq

// ==== verilog/kei_pkg.sv ====
// Purpose: shared types for the key edge interrupt block
// Assumes: nothing beyond the register header
// Notes: access kinds of the cpu register port
package kei_pkg;
  typedef enum logic [1:0] {
    KEI_ACC_NONE,
    KEI_ACC_BYTE,
    KEI_ACC_BIT_SET,
    KEI_ACC_BIT_CLR
  } kei_acc_t;
endpackage : kei_pkg

// ==== verilog/kei_regs.svh ====
// Purpose: register map and constants for the key edge interrupt block
// Assumes: byte-wide special function registers on a cpu-side access port
// Notes: addresses are the cpu's memory addresses of the registers
`ifndef KEI_REGS_SVH
`define KEI_REGS_SVH
`define KEI_ADDR_W 20
`define KEI_KEY_EN_ADDR 20'h0ff37
`define KEI_DIR_ADDR 20'hfff27
`define KEI_KEY_EN_RESET 8'h00
`define KEI_DIR_RESET 8'hff
`define KEI_LOW_WIDTH_NS 250
`define KEI_CLK_PERIOD_NS 8
`endif

// ==== verilog/kei_sync.sv ====
// Purpose: three-stage synchroniser for one asynchronous pin
// Assumes: input may change at any time
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module kei_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // accept a change only when the last two stages agree
  always_comb begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r) begin
      lvl_nxt = s3_r;
    end
  end

  // first stage is read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      lvl_r <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule : kei_sync
